// [icf_field_model.sv]
`timescale 1ns/1ps
module icf_field_model
	import icf_pkg::*;
(
	// Clock and reset.
	input  wire logic core_clk,
	input  wire logic nrst,
	// Contact level wanted by the bench.
	input  wire logic lvl_req,
	// Field contact.
	output logic      field_in
);
	// The contact is re-timed once, so it moves just after an edge as a synchronised input would.
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			field_in <= 1'b0;
		else
			field_in <= lvl_req;
	end
endmodule

// [icf_pkg.sv]
package icf_pkg;

	// Time base: one timestamp unit is one millisecond.
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned MS_NS         = 1000000;
	localparam int unsigned TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;

	// Register byte offsets.
	localparam logic [7:0] REG_DEBOUNCE = 8'h00;
	localparam logic [7:0] REG_WINDOW   = 8'h04;
	localparam logic [7:0] REG_THRESH   = 8'h08;
	localparam logic [7:0] REG_LOCKOUT  = 8'h0C;
	localparam logic [7:0] REG_STATUS   = 8'h10;
	localparam logic [7:0] REG_EVT_TIME = 8'h14;
	localparam logic [7:0] REG_EVT_INFO = 8'h18;
	localparam logic [7:0] REG_IRQ_STAT = 8'h1C;
	localparam logic [7:0] REG_IRQ_CLR  = 8'h20;
	localparam logic [7:0] REG_IRQ_EN   = 8'h24;
	localparam logic [7:0] REG_NOW      = 8'h28;

	// Reset values, in milliseconds and events.
	localparam logic [15:0] DEBOUNCE_RST = 16'h00FA;
	localparam logic [15:0] WINDOW_RST   = 16'h03E8;
	localparam logic [7:0]  THRESH_RST   = 8'h04;
	localparam logic [15:0] LOCKOUT_RST  = 16'h0320;

	// Status field positions.
	localparam int ST_STATE   = 0;
	localparam int ST_BLOCKED = 1;
	localparam int ST_PEND    = 2;
	localparam int ST_CNT_LSB = 8;
	localparam int ST_LVL_LSB = 16;

	// Interrupt status bits.
	localparam int IRQ_EVENT   = 0;
	localparam int IRQ_BLOCK   = 1;
	localparam int IRQ_RELEASE = 2;
	localparam int IRQ_OVFL    = 3;
	localparam int IRQ_W       = 4;

	// Event queue depth.
	localparam int QUEUE_AW    = 4;
	localparam int QUEUE_DEPTH = 16;

	typedef struct packed {
		logic [31:0] ts;
		logic        state;
		logic        block;
	} icf_evt_t;

endpackage

// [icf_top.sv]
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - Report change only after debounce time.
// - Timestamp is the physical transition instant.
// - Pulses shorter than debounce are discarded.
// - Unblocked events enqueue immediately, bump counter.
// - Events within window keep accumulating count.
// - Gap over window restarts count at one.
// - Count reaching threshold blocks further events.
// - Block holds until input stable past lockout.
// - Transition during lockout restarts lockout timer.
// - Lockout expiry enqueues block-off, same state.
// - Release timestamp is now minus debounce.
// - After release, transitions pass and count again.
module icf_top
	import icf_pkg::*;
#(
	parameter int unsigned TICK_LEN = TICK_CYCLES
)(
	// Clock and reset.
	input  wire logic        core_clk,
	input  wire logic        nrst,
	// Field input.
	input  wire logic        field_in,
	// Wishbone slave.
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Interrupt.
	output logic             irq
);

	logic [16:0] tick_cnt;
	logic        tick;
	logic [31:0] now;
	logic [15:0] debounce;
	logic [15:0] window;
	logic [7:0]  thresh;
	logic [15:0] lockout;
	logic        deb_state;
	logic        pending;
	logic [15:0] dcnt;
	logic [31:0] edge_ts;
	logic        raw_q;
	logic        blocked;
	logic [7:0]  ccnt;
	logic [31:0] last_ts;
	logic [15:0] lcnt;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_en;
	icf_evt_t    queue [QUEUE_DEPTH];
	logic [QUEUE_AW:0] wr_ptr;
	logic [QUEUE_AW:0] rd_ptr;

	function automatic logic [QUEUE_AW-1:0] qidx(input logic [QUEUE_AW:0] p);
		return p[QUEUE_AW-1:0];
	endfunction

	// Millisecond time base.
	assign tick = (tick_cnt == 17'(TICK_LEN - 1));

	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			tick_cnt <= 17'h00000;
			now      <= 32'h00000000;
		end
		else
		begin
			tick_cnt <= tick ? 17'h00000 : tick_cnt + 17'h00001;
			now      <= tick ? now + 32'h00000001 : now;
		end

	// Debounce: a change is accepted on the tick that brings its tick count to the setting; the first tick may be partial.
	wire differs   = (field_in != deb_state);
	wire start     = differs && !pending;
	wire cancel    = pending && !differs;
	wire deb_done  = pending && differs && (debounce == 16'h0000 || (tick && dcnt + 16'h0001 >= debounce));
	wire deb_evt   = deb_done;
	wire raw_edge  = (field_in != raw_q);

	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			deb_state <= 1'b0;
			pending   <= 1'b0;
			dcnt      <= 16'h0000;
			edge_ts   <= 32'h00000000;
			raw_q     <= 1'b0;
		end
		else
		begin
			raw_q <= field_in;
			if (start)
			begin
				pending <= 1'b1;
				dcnt    <= 16'h0000;
				edge_ts <= now;
			end
			else if (cancel)
				pending <= 1'b0;
			else if (deb_done)
			begin
				pending   <= 1'b0;
				deb_state <= field_in;
			end
			else if (pending && tick)
				dcnt <= dcnt + 16'h0001;
		end

	// Chatter counting and blocking.
	wire [31:0] gap      = edge_ts - last_ts;
	wire        restart  = (gap > {16'h0000, window});
	wire [7:0]  cnt_inc  = (ccnt == 8'hFF) ? ccnt : ccnt + 8'h01;
	wire [7:0]  next_cnt = restart ? 8'h01 : cnt_inc;
	wire        pass     = deb_evt && !blocked;
	wire        trip     = pass && (next_cnt >= thresh);
	wire        lock_inc = tick && (lcnt != 16'hFFFF);
	wire        release_evt = blocked && !raw_edge && tick && (lcnt + 16'h0001 > lockout);

	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			blocked <= 1'b0;
			ccnt    <= 8'h00;
			last_ts <= 32'h00000000;
			lcnt    <= 16'h0000;
		end
		else
		begin
			if (pass)
			begin
				ccnt    <= next_cnt;
				last_ts <= edge_ts;
			end
			if (trip)
			begin
				blocked <= 1'b1;
				lcnt    <= 16'h0000;
			end
			else if (blocked && raw_edge)
				lcnt <= 16'h0000;
			else if (release_evt)
			begin
				blocked <= 1'b0;
				ccnt    <= 8'h00;
			end
			else if (blocked && lock_inc)
				lcnt <= lcnt + 16'h0001;
		end

	// Event queue write side: only one source can push in a cycle.
	icf_evt_t push_data;
	wire      push  = pass || release_evt;
	wire      full  = (wr_ptr == {~rd_ptr[QUEUE_AW], rd_ptr[QUEUE_AW-1:0]});
	wire      empty = (wr_ptr == rd_ptr);
	wire [QUEUE_AW:0] level = wr_ptr - rd_ptr;

	assign push_data.ts    = release_evt ? now - {16'h0000, debounce} : edge_ts;
	assign push_data.state = release_evt ? deb_state : field_in;
	assign push_data.block = release_evt ? 1'b0 : trip;

	// Bus decode.
	wire      req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire      wr    = req && wb_we_i;
	wire      pop   = wr && (wb_adr_i == REG_EVT_INFO) && !empty;
	icf_evt_t head;
	assign head = queue[qidx(rd_ptr)];

	always_ff @(posedge core_clk)
		if (push && !full)
			queue[qidx(wr_ptr)] <= push_data;

	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			if (push && !full)
				wr_ptr <= wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= rd_ptr + 1'b1;
		end

	// Interrupt sources; a set in the clearing cycle wins.
	wire [IRQ_W-1:0] irq_set = {push && full, release_evt, trip, push && !full};
	wire [IRQ_W-1:0] irq_clr = (wr && wb_adr_i == REG_IRQ_CLR && wb_sel_i[0]) ? wb_dat_i[IRQ_W-1:0] : '0;

	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
			irq_stat <= '0;
		else
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;

	assign irq = |(irq_stat & irq_en);

	// Register writes; the setting and enable words are written only with all byte lanes.
	wire wr_all = wr && (wb_sel_i == 4'hF);

	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			debounce <= DEBOUNCE_RST;
			window   <= WINDOW_RST;
			thresh   <= THRESH_RST;
			lockout  <= LOCKOUT_RST;
			irq_en   <= '0;
		end
		else if (wr_all)
			case (wb_adr_i)
				REG_DEBOUNCE: debounce <= wb_dat_i[15:0];
				REG_WINDOW:   window   <= wb_dat_i[15:0];
				REG_THRESH:   thresh   <= wb_dat_i[7:0];
				REG_LOCKOUT:  lockout  <= wb_dat_i[15:0];
				REG_IRQ_EN:   irq_en   <= wb_dat_i[IRQ_W-1:0];
				default:      ;
			endcase

	// Read mux; unmapped addresses read zero and are still acknowledged.
	logic [31:0] rd_val;
	always_comb
	begin
		rd_val = 32'h00000000;
		case (wb_adr_i)
			REG_DEBOUNCE: rd_val[15:0] = debounce;
			REG_WINDOW:   rd_val[15:0] = window;
			REG_THRESH:   rd_val[7:0]  = thresh;
			REG_LOCKOUT:  rd_val[15:0] = lockout;
			REG_STATUS:
			begin
				rd_val[ST_STATE]   = deb_state;
				rd_val[ST_BLOCKED] = blocked;
				rd_val[ST_PEND]    = pending;
				rd_val[ST_CNT_LSB +: 8] = ccnt;
				rd_val[ST_LVL_LSB +: QUEUE_AW+1] = level;
			end
			REG_EVT_TIME: rd_val = empty ? 32'h00000000 : head.ts;
			REG_EVT_INFO: rd_val[2:0] = {!empty, empty ? 2'b00 : {head.block, head.state}};
			REG_IRQ_STAT: rd_val[IRQ_W-1:0] = irq_stat;
			REG_IRQ_EN:   rd_val[IRQ_W-1:0] = irq_en;
			REG_NOW:      rd_val = now;
			default:      rd_val = 32'h00000000;
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst)
		if (!nrst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= req;
			wb_dat_o <= (req && !wb_we_i) ? rd_val : 32'h00000000;
		end

	// Checks.
	sequence s_trip;
		pass && (next_cnt >= thresh);
	endsequence
	sequence s_blocked_quiet;
		blocked && !release_evt;
	endsequence
	property p_ack_once;
		@(posedge core_clk) disable iff (!nrst) wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");
	property p_deb_delay;
		@(posedge core_clk) disable iff (!nrst)
		deb_evt && debounce != 16'h0000 |-> tick && dcnt == debounce - 16'h0001;
	endproperty
	a_deb_delay: assert property (p_deb_delay) else $error("debounce accepted early");
	property p_evt_ts;
		@(posedge core_clk) disable iff (!nrst) pass |-> push_data.ts == edge_ts && edge_ts <= now;
	endproperty
	a_evt_ts: assert property (p_evt_ts) else $error("event time not edge time");

	property p_short_pulse;
		@(posedge core_clk) disable iff (!nrst) cancel |=> !pending && deb_state == $past(deb_state);
	endproperty
	a_short_pulse: assert property (p_short_pulse) else $error("short pulse not discarded");

	property p_pass_push;
		@(posedge core_clk) disable iff (!nrst) deb_evt && !blocked |-> push ##1 ccnt != 8'h00;
	endproperty
	a_pass_push: assert property (p_pass_push) else $error("unblocked event not queued");

	property p_accumulate;
		@(posedge core_clk) disable iff (!nrst)
		pass && !restart && ccnt != 8'hFF |=> ccnt == $past(ccnt) + 8'h01;
	endproperty
	a_accumulate: assert property (p_accumulate) else $error("count did not accumulate");

	property p_restart;
		@(posedge core_clk) disable iff (!nrst) pass && restart && !trip |=> ccnt == 8'h01;
	endproperty
	a_restart: assert property (p_restart) else $error("count not restarted at one");

	property p_block_on;
		@(posedge core_clk) disable iff (!nrst) s_trip |-> push_data.block ##1 blocked;
	endproperty
	a_block_on: assert property (p_block_on) else $error("threshold did not block");

	property p_block_quiet;
		@(posedge core_clk) disable iff (!nrst) s_blocked_quiet |-> !push;
	endproperty
	a_block_quiet: assert property (p_block_quiet) else $error("event passed while blocked");

	property p_lock_restart;
		@(posedge core_clk) disable iff (!nrst) blocked && raw_edge |=> blocked && lcnt == 16'h0000;
	endproperty
	a_lock_restart: assert property (p_lock_restart) else $error("lockout not restarted");

	property p_release;
		@(posedge core_clk) disable iff (!nrst)
		release_evt |-> push && !push_data.block && push_data.state == deb_state ##1 !blocked && ccnt == 8'h00;
	endproperty
	a_release: assert property (p_release) else $error("release event wrong");

	property p_release_ts;
		@(posedge core_clk) disable iff (!nrst) release_evt |-> push_data.ts == now - {16'h0000, debounce};
	endproperty
	a_release_ts: assert property (p_release_ts) else $error("release time wrong");

	property p_queue_order;
		@(posedge core_clk) disable iff (!nrst) push && !full && empty |=> head == $past(push_data);
	endproperty
	a_queue_order: assert property (p_queue_order) else $error("queue head wrong");

endmodule

// [input_chatter_filter_tb_top.sv]
`timescale 1ns/1ps
module input_chatter_filter_tb_top;
	import icf_pkg::*;
	localparam int T = 10;
	localparam int D = 5;
	localparam int W = 20;
	localparam int L = 8;
	localparam logic [31:0] SM = 32'h001FFF03;
	logic        core_clk = 1'b0;
	logic        nrst     = 1'b0;
	logic        lvl      = 1'b0;
	logic        cyc      = 1'b0;
	logic        stb      = 1'b0;
	logic        we       = 1'b0;
	logic [7:0]  adr      = 8'h00;
	logic [3:0]  sel      = 4'h0;
	logic [31:0] dat      = 32'h0;
	logic        field_in;
	logic        wb_ack_o;
	logic        irq;
	logic [31:0] wb_dat_o;
	logic [31:0] rd_v;
	logic [31:0] t0;
	logic [31:0] ts;
	logic [31:0] nw;
	int          errors = 0;
	int          checks = 0;
	int          cyc_n  = 0;
	logic [63:0] exp_q[$];
	logic [7:0]  ra[6] = '{REG_DEBOUNCE, REG_WINDOW, REG_THRESH, REG_LOCKOUT, REG_IRQ_EN, 8'h30};
	logic [31:0] rv[6] = '{32'(DEBOUNCE_RST), 32'(WINDOW_RST), 32'(THRESH_RST), 32'(LOCKOUT_RST), 32'h0, 32'h0};
	logic [1:0]  qe[5] = '{2'b00, 2'b01, 2'b00, 2'b11, 2'b01};

	always #5 core_clk = ~core_clk;

	icf_field_model fld (.core_clk(core_clk), .nrst(nrst), .lvl_req(lvl), .field_in(field_in));

	icf_top #(.TICK_LEN(T)) uut (.core_clk(core_clk), .nrst(nrst), .field_in(field_in), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		checks++;
		if ((got & m) !== (exp & m))
		begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task end_of_test;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Read answers are compared at the edge that samples ack high; an answer nobody asked for is a mismatch.
	always @(posedge core_clk)
	begin
		if (wb_ack_o === 1'b1 && we === 1'b0)
		begin
			if (exp_q.size() == 0)
				chk(32'h1, 32'h0, 32'h1);
			else
			begin
				chk(wb_dat_o, exp_q[0][63:32], exp_q[0][31:0]);
				void'(exp_q.pop_front());
			end
		end
	end

	always @(posedge core_clk)
	begin
		cyc_n++;
		if (cyc_n == 6000)
		begin
			errors++;
			end_of_test;
		end
	end

	// The request stands until the edge that samples ack high; read data is taken and the request dropped there.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		@(posedge core_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hF;
		if (!w)
			exp_q.push_back({d, m});
		do
		begin
			@(posedge core_clk);
		end
		while (wb_ack_o !== 1'b1);
		rd_v = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		wb(1'b0, a, e, m);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 32'h0);
	endtask

	task automatic tog(input int n);
		@(posedge core_clk);
		lvl <= ~lvl;
		repeat (n) @(posedge core_clk);
	endtask

	task automatic pop(input logic [1:0] sb);
		rd(REG_EVT_TIME, 32'h0, 32'h0);
		ts = rd_v;
		rd(REG_EVT_INFO, {29'h0, 1'b1, sb}, 32'h7);
		wr(REG_EVT_INFO, 32'h0);
	endtask

	function automatic logic [31:0] st(int q, int c, int b, int s);
		return {11'h0, 5'(q), 8'(c), 6'h0, 1'(b), 1'(s)};
	endfunction

	initial
	begin
		void'($urandom(32'h2a48));
		repeat (4) @(posedge core_clk);
		nrst <= 1'b1;
		for (int i = 0; i < 6; i++)
			rd(ra[i], rv[i], 32'hFFFFFFFF);
		wr(REG_DEBOUNCE, D);
		wr(REG_WINDOW, W);
		wr(REG_LOCKOUT, L);
		for (int i = 0; i < 2; i++)
		begin
			tog(1 + $urandom % 30);
			tog(80);
			rd(REG_STATUS, st(0, 0, 0, 0), SM);
		end
		rd(REG_NOW, 32'h0, 32'h0);
		t0 = rd_v;
		tog(36);
		rd(REG_STATUS, st(0, 0, 0, 0), SM);
		repeat (20) @(posedge core_clk);
		rd(REG_STATUS, st(1, 1, 0, 1), SM);
		chk({31'h0, irq}, 32'h0, 32'h1);
		rd(REG_IRQ_STAT, 32'h1, 32'h1);
		wr(REG_IRQ_EN, 32'hF);
		chk({31'h0, irq}, 32'h1, 32'h1);
		pop(2'b01);
		chk({31'h0, (ts - t0) <= 1}, 32'h1, 32'h1);
		wr(REG_IRQ_CLR, 32'hF);
		chk({31'h0, irq}, 32'h0, 32'h1);
		repeat ((W + 5) * T) @(posedge core_clk);
		tog((D + 1) * T);
		rd(REG_STATUS, st(1, 1, 0, 0), SM);
		for (int i = 2; i < 5; i++)
		begin
			repeat ($urandom % 10) @(posedge core_clk);
			tog((D + 1) * T);
			rd(REG_STATUS, st(i, i, i == 4, i % 2 == 0), SM);
		end
		rd(REG_IRQ_STAT, 32'h2, 32'h2);
		tog(6 * T);
		tog(6 * T);
		rd(REG_STATUS, st(4, 4, 1, 1), SM);
		repeat (6 * T) @(posedge core_clk);
		rd(REG_STATUS, st(5, 0, 0, 1), SM);
		rd(REG_IRQ_STAT, 32'h4, 32'h4);
		rd(REG_NOW, 32'h0, 32'h0);
		nw = rd_v;
		for (int i = 0; i < 5; i++)
			pop(qe[i]);
		// The release stamp lies one debounce setting before its own instant, a few ticks before the time read.
		chk({31'h0, (nw - ts) >= D + 2 && (nw - ts) <= D + 5}, 32'h1, 32'h1);
		chk({31'h0, irq}, 32'h1, 32'h1);
		wr(REG_IRQ_CLR, 32'hF);
		chk({31'h0, irq}, 32'h0, 32'h1);
		tog((D + 1) * T);
		rd(REG_STATUS, st(1, 1, 0, 0), SM);
		pop(2'b00);
		// With a zero window every event restarts the count, so seventeen events overrun the sixteen entries.
		wr(REG_WINDOW, 32'h0);
		for (int i = 0; i < 17; i++)
			tog((D + 1) * T);
		rd(REG_STATUS, st(16, 1, 0, 1), SM);
		rd(REG_IRQ_STAT, 32'h8, 32'h8);
		pop(2'b01);
		end_of_test;
	end
endmodule
